// >>> logic/bridge_prot_map.svh
// Constants shared by the protection device end and the controller end.
// Assumes inclusion by bare name from files under logic/.
`ifndef BRIDGE_PROT_MAP_SVH
`define BRIDGE_PROT_MAP_SVH

// Number of half bridges
`define BRIDGE_COUNT 3
// Protection mode select levels
`define MODE_CYCLE_LIMIT 1'b0
`define MODE_LATCHED 1'b1
// Recharge pulse on the low side, least time in ns
`define RECHARGE_MIN_NS 50
`define CLK_PERIOD_NS 10
`define RECHARGE_CYCLES ((`RECHARGE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Flag reset values (released, high)
`define FLAG_RESET 1'b1

`endif

// >>> logic/bridge_prot_pkg.sv
// Types shared by both ends of the protection link.
// Assumes the map header supplies numeric constants.
package bridge_prot_pkg;
  // Protection mode
  typedef enum logic {
    MODE_CYCLE     = 1'b0,
    MODE_LATCH     = 1'b1
  } prot_mode_t;
  // Per-bridge state, one-hot
  typedef enum logic [3:0] {
    HB_RUN         = 4'b0001,
    HB_LIMIT_HI    = 4'b0010,
    HB_LIMIT_LO    = 4'b0100,
    HB_SHUT        = 4'b1000
  } hb_state_t;
endpackage

// >>> logic/bridge_prot_if.sv
// Link between the motor controller and the protection device.
// Assumes both ends run on sys_clk; flags are wired, not open drain, here.
`timescale 1ns/1ps
interface bridge_prot_if;
  logic [2:0] phase_pwm_in;
  logic [2:0] bridge_clear_n;
  logic       protect_mode_sel;
  logic       temp_warning_n;
  logic       shutdown_flag_n;

  modport device (
    input  phase_pwm_in,
    input  bridge_clear_n,
    input  protect_mode_sel,
    output temp_warning_n,
    output shutdown_flag_n
  );
  modport ctrl (
    output phase_pwm_in,
    output bridge_clear_n,
    output protect_mode_sel,
    input  temp_warning_n,
    input  shutdown_flag_n
  );
endinterface

// >>> logic/bridge_prot_device.sv
// Protection and fault-state logic of a three half bridge driver.
// Assumes analog detectors arrive as asynchronous levels and are synchronised here.
`timescale 1ns/1ps
`include "bridge_prot_map.svh"

// Function
// (RULE1) Warning flag low above first temperature
// (RULE2) Thermal shutdown: all bridges off, flag low
// (RULE3) Thermal shutdown latched until all clears low
// (RULE4) Power-up clear resets overcurrent logic
// (RULE5) Supply low forces outputs off, flag low
// (RULE6) Supply recovery resumes operation automatically
// (RULE7) Clear low forces its bridge off
// (RULE8) Cycle mode: own clear rising edge clears
// (RULE9) Latched faults need rising edges on all
// (RULE10) Exactly two modes: cycle or latched
// (RULE11) Controller holds mode low for cycle
// (RULE12) Controller gives low-side recharge pulse
// (RULE13) Two-quadrant use prefers latched mode
// (RULE14) Flag pair encodes warning and shutdown
// (RULE15) High-side overcurrent: low side on till cycle
// (RULE16) Low-side overcurrent: both off till cycle
// (RULE17) Latched mode: any overcurrent shuts down
// (RULE18) Normal bridge follows pwm, never both on
// (RULE19) Shutdown flag low while any shutdown remains
module bridge_prot_device import bridge_prot_pkg::*; #(
  parameter int NB = `BRIDGE_COUNT
) (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rst,
  // Link to the controller
  bridge_prot_if.device      link,
  // Analog detector levels, asynchronous
  input  wire logic          over_temp_warn,
  input  wire logic          over_temp_shut,
  input  wire logic          supply_low,
  input  wire logic          power_up_clear,
  input  wire logic [NB-1:0] oc_high,
  input  wire logic [NB-1:0] oc_low,
  input  wire logic [NB-1:0] oc_short,
  // Gate drive
  output logic      [NB-1:0] gate_high,
  output logic      [NB-1:0] gate_low
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int SW = 4 + 4 * NB;
  logic [SW-1:0] raw_in;
  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;
  // Pins from the controller share sys_clk here, but they are synced too
  assign raw_in = {over_temp_warn, over_temp_shut, supply_low, power_up_clear,
                   oc_high, oc_low, oc_short, link.bridge_clear_n};
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end
  logic          warn_s, tshut_s, uv_s, por_s;
  logic [NB-1:0] ochi_s, oclo_s, short_s, clr_s;
  assign {warn_s, tshut_s, uv_s, por_s, ochi_s, oclo_s, short_s, clr_s} = sync2_reg;

  // PWM and mode pins, two flops
  logic [NB:0] pm1_reg;
  logic [NB:0] pm2_reg;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pm1_reg <= '0;
      pm2_reg <= '0;
    end else begin
      pm1_reg <= {link.protect_mode_sel, link.phase_pwm_in};
      pm2_reg <= pm1_reg;
    end
  end
  prot_mode_t    mode;
  logic [NB-1:0] pwm_s;
  assign mode  = prot_mode_t'(pm2_reg[NB]); // RULE10
  assign pwm_s = pm2_reg[NB-1:0];

  // ----------------------------------------------------------------
  // Edge history and latches
  // ----------------------------------------------------------------
  logic [NB-1:0] clr_d_reg, clr_d_next;
  logic [NB-1:0] pwm_d_reg, pwm_d_next;
  logic [NB-1:0] seen_reg, seen_next;  // Rising edges seen since latched fault
  logic          tlatch_reg, tlatch_next;
  logic          glatch_reg, glatch_next; // Latched-mode overcurrent shutdown
  hb_state_t     st_reg [NB];
  hb_state_t     st_next [NB];
  logic [NB-1:0] rise, pwm_rise, any_oc;

  assign rise     = clr_s & ~clr_d_reg;
  assign pwm_rise = pwm_s & ~pwm_d_reg;
  assign any_oc   = ochi_s | oclo_s | short_s;

  // Next-state for latches and bridge states
  always_comb begin
    clr_d_next  = clr_s;
    pwm_d_next  = pwm_s;
    tlatch_next = tlatch_reg;
    glatch_next = glatch_reg;
    seen_next   = seen_reg;
    for (int i = 0; i < NB; i++) begin
      st_next[i] = st_reg[i];
    end
    // Pin release of global latched faults waits until every clear has risen
    if (tlatch_reg || glatch_reg) begin
      seen_next = seen_reg | rise;
      if (&(seen_reg | rise) && !tshut_s && !(|any_oc)) begin // RULE9 RULE3
        tlatch_next = 1'b0;
        glatch_next = 1'b0;
        seen_next   = '0;
      end
    end
    // Set wins over the pin clear; power-up clear wins over the glatch set
    if (tshut_s) begin
      tlatch_next = 1'b1; // RULE2 RULE3
    end
    if (mode == MODE_LATCH && (|any_oc)) begin
      glatch_next = 1'b1; // RULE17
    end
    if ((tshut_s || (mode == MODE_LATCH && (|any_oc))) && !tlatch_reg && !glatch_reg) begin
      seen_next = '0;
    end
    // Per-bridge cycle-limit states
    for (int i = 0; i < NB; i++) begin
      unique case (st_reg[i])
        HB_RUN: begin
          if (mode == MODE_CYCLE) begin
            if (short_s[i]) begin
              st_next[i] = HB_SHUT;
            end else if (ochi_s[i]) begin
              st_next[i] = HB_LIMIT_HI; // RULE15
            end else if (oclo_s[i]) begin
              st_next[i] = HB_LIMIT_LO; // RULE16
            end
          end
        end
        HB_LIMIT_HI, HB_LIMIT_LO: begin
          if (short_s[i]) begin
            st_next[i] = HB_SHUT;
          end else if (pwm_rise[i] || mode == MODE_LATCH) begin
            st_next[i] = HB_RUN; // Next cycle restores normal drive
          end
        end
        HB_SHUT: begin
          if (rise[i] && !short_s[i]) begin
            st_next[i] = HB_RUN; // RULE8
          end
        end
        default: st_next[i] = HB_SHUT;
      endcase
      // Power-up clear resets overcurrent detection
      if (por_s) begin
        st_next[i] = HB_RUN; // RULE4
      end
    end
    if (por_s) begin
      glatch_next = 1'b0; // RULE4
    end
  end

  // State registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clr_d_reg  <= '0;
      pwm_d_reg  <= '0;
      seen_reg   <= '0;
      tlatch_reg <= 1'b0;
      glatch_reg <= 1'b0;
      for (int i = 0; i < NB; i++) begin
        st_reg[i] <= HB_RUN;
      end
    end else begin
      clr_d_reg  <= clr_d_next;
      pwm_d_reg  <= pwm_d_next;
      seen_reg   <= seen_next;
      tlatch_reg <= tlatch_next;
      glatch_reg <= glatch_next;
      for (int i = 0; i < NB; i++) begin
        st_reg[i] <= st_next[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Gate drive and flags
  // ----------------------------------------------------------------
  logic [NB-1:0] gh_next, gl_next;
  logic          warn_next, shut_next;
  logic          all_off;
  logic          any_shut;  // Some bridge sits in its own shutdown state
  logic          warn_reg, shut_reg;
  logic [NB-1:0] gh_reg, gl_reg;

  // Supply low and power-up clear force everything off; recovery is automatic
  assign all_off = tlatch_reg || glatch_reg || uv_s || por_s; // RULE5 RULE6 RULE2

  always_comb begin
    any_shut = 1'b0;
    for (int i = 0; i < NB; i++) begin
      gh_next[i] = 1'b0;
      gl_next[i] = 1'b0;
      any_shut   = any_shut | (st_reg[i] == HB_SHUT); // Scales with NB
      if (!all_off && clr_s[i]) begin // RULE7
        unique case (st_reg[i])
          HB_RUN: begin
            gh_next[i] = pwm_s[i];  // RULE18
            gl_next[i] = ~pwm_s[i]; // RULE18
          end
          HB_LIMIT_HI: gl_next[i] = 1'b1; // RULE15
          HB_LIMIT_LO: gl_next[i] = 1'b0; // RULE16
          HB_SHUT:     gl_next[i] = 1'b0;
          default:     gl_next[i] = 1'b0;
        endcase
      end
    end
    warn_next = ~warn_s; // RULE1 RULE14
    shut_next = ~(all_off || any_shut); // RULE19 RULE14
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gh_reg   <= '0;
      gl_reg   <= '0;
      warn_reg <= `FLAG_RESET;
      shut_reg <= `FLAG_RESET;
    end else begin
      gh_reg   <= gh_next;
      gl_reg   <= gl_next;
      warn_reg <= warn_next;
      shut_reg <= shut_next;
    end
  end

  assign gate_high            = gh_reg;
  assign gate_low             = gl_reg;
  assign link.temp_warning_n  = warn_reg;
  assign link.shutdown_flag_n = shut_reg;
endmodule

// >>> logic/bridge_prot_ctrl.sv
// Controller end: drives pwm, clear pins and mode, watches the flags.
// Assumes user requests arrive on sys_clk; flags from the device are synced.
`timescale 1ns/1ps
`include "bridge_prot_map.svh"

module bridge_prot_ctrl import bridge_prot_pkg::*; #(
  parameter int NB = `BRIDGE_COUNT
) (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rst,
  // Link to the device
  bridge_prot_if.ctrl        link,
  // User side
  input  wire logic [NB-1:0] pwm_req,
  input  wire logic [NB-1:0] bridge_enable,
  input  wire logic          latched_sel,
  input  wire logic          clear_req,
  output logic               warn_seen,
  output logic               fault_seen,
  output logic               clear_busy
);
  // ----------------------------------------------------------------
  // Flag synchronisers
  // ----------------------------------------------------------------
  logic [1:0] f1_reg, f2_reg;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      f1_reg <= 2'h3;
      f2_reg <= 2'h3;
    end else begin
      f1_reg <= {link.temp_warning_n, link.shutdown_flag_n};
      f2_reg <= f1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Pwm with low-side recharge stretch and clear pulse
  // ----------------------------------------------------------------
  localparam logic [3:0] RECH = 4'(`RECHARGE_CYCLES);
  logic [NB-1:0] pwm_reg, pwm_next;
  logic [NB-1:0] clr_reg, clr_next;
  logic [3:0]    lo_cnt_reg [NB];
  logic [3:0]    lo_cnt_next [NB];
  logic          busy_reg, busy_next;
  logic          mode_reg, mode_next;

  always_comb begin
    busy_next = busy_reg;
    clr_next  = bridge_enable;
    mode_next = latched_sel ? `MODE_LATCHED : `MODE_CYCLE_LIMIT; // RULE11 RULE13
    // A clear pulse drives all pins low one cycle, then releases them
    if (clear_req && !busy_reg) begin
      busy_next = 1'b1;
      clr_next  = '0; // RULE3 RULE9 RULE8
    end else if (busy_reg) begin
      busy_next = 1'b0;
    end
    for (int i = 0; i < NB; i++) begin
      lo_cnt_next[i] = lo_cnt_reg[i];
      pwm_next[i]    = pwm_req[i];
      // Hold low long enough to recharge the bootstrap before rising
      if (!pwm_reg[i] && lo_cnt_reg[i] < RECH) begin
        lo_cnt_next[i] = lo_cnt_reg[i] + 4'h1;
        pwm_next[i]    = 1'b0; // RULE12
      end
      if (pwm_next[i]) begin
        lo_cnt_next[i] = 4'h0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pwm_reg  <= '0;
      clr_reg  <= '0;
      busy_reg <= 1'b0;
      mode_reg <= 1'b0;
      for (int i = 0; i < NB; i++) begin
        lo_cnt_reg[i] <= 4'h0;
      end
    end else begin
      pwm_reg  <= pwm_next;
      clr_reg  <= clr_next;
      busy_reg <= busy_next;
      mode_reg <= mode_next;
      for (int i = 0; i < NB; i++) begin
        lo_cnt_reg[i] <= lo_cnt_next[i];
      end
    end
  end

  assign link.phase_pwm_in     = pwm_reg;
  assign link.bridge_clear_n   = clr_reg;
  assign link.protect_mode_sel = mode_reg;
  assign warn_seen             = ~f2_reg[1];
  assign fault_seen            = ~f2_reg[0];
  assign clear_busy            = busy_reg;
endmodule

// >>> tb/bridge_prot_sva.sv
// Checker on the link and on the device's detector and gate pins.
// Assumes tb_top instantiates it beside the link, three bridges.
`timescale 1ns/1ps
module bridge_prot_sva (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // Link signals
  input wire logic [2:0] phase_pwm_in,
  input wire logic [2:0] bridge_clear_n,
  input wire logic       protect_mode_sel,
  input wire logic       temp_warning_n,
  input wire logic       shutdown_flag_n,
  // Device detectors and gates
  input wire logic       over_temp_warn,
  input wire logic       over_temp_shut,
  input wire logic       supply_low,
  input wire logic       power_up_clear,
  input wire logic [2:0] oc_high,
  input wire logic [2:0] oc_low,
  input wire logic [2:0] oc_short,
  input wire logic [2:0] gate_high,
  input wire logic [2:0] gate_low
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // Quiet counter
  // ------------------------------------------------------------
  // A flag release while every cause stood still means a latch let go
  logic [15:0] cause_reg;
  logic [15:0] cause_next;
  logic [3:0]  quiet_reg;
  logic [3:0]  quiet_next;
  logic        calm;
  always_comb begin
    cause_next = {bridge_clear_n, protect_mode_sel, over_temp_shut, supply_low,
                  power_up_clear, oc_high, oc_low, oc_short};
    quiet_next = (cause_next != cause_reg) ? 4'h0 : quiet_reg + {3'h0, quiet_reg != 4'hf};
    calm = !over_temp_shut && !supply_low && !power_up_clear && (&bridge_clear_n)
           && !protect_mode_sel && (oc_short == 3'h0);
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cause_reg <= 16'h0000;
      quiet_reg <= 4'h0;
    end else begin
      cause_reg <= cause_next;
      quiet_reg <= quiet_next;
    end
  end
  // Level causes: two sync stages plus the output register take four samples;
  // latched causes pass one more register, so they take five
  sequence s_hot;
    over_temp_shut [*5];
  endsequence
  a_warn_low: assert property (over_temp_warn [*4] |-> !temp_warning_n)
    else $error("warning flag not low");
  a_thermal_off: assert property (s_hot |-> gate_high == 3'h0 && gate_low == 3'h0
    && !shutdown_flag_n) else $error("thermal shutdown missing");
  a_latch_holds: assert property (!shutdown_flag_n && quiet_reg > 4'h6
    |=> !shutdown_flag_n) else $error("shutdown released without cause");
  a_supply_off: assert property (supply_low [*4] |-> gate_high == 3'h0
    && gate_low == 3'h0 && !shutdown_flag_n) else $error("supply low not off");
  a_clear_puc: assert property (power_up_clear [*4] |-> gate_high == 3'h0
    && gate_low == 3'h0 && !shutdown_flag_n) else $error("power-up clear not off");
  a_latched_trip: assert property ((protect_mode_sel && oc_high != 3'h0) [*5]
    |-> gate_high == 3'h0 && !shutdown_flag_n) else $error("latched trip missing");
  a_never_both: assert property ((gate_high & gate_low) == 3'h0)
    else $error("both fets on");
  for (genvar i = 0; i < 3; i++) begin : g_hb
    a_pin_off: assert property (!bridge_clear_n[i] [*4] |-> !gate_high[i] && !gate_low[i])
      else $error("cleared bridge driven");
    a_pwm_rest: assert property ($fell(phase_pwm_in[i]) |=> !phase_pwm_in[i] [*4])
      else $error("pwm low pulse too short");
    a_high_limit: assert property ((calm && oc_high[i] && !oc_low[i] && phase_pwm_in[i]
      && shutdown_flag_n) [*8] |-> !gate_high[i] && gate_low[i]) else $error("high limit");
    a_low_limit: assert property ((calm && oc_low[i] && !oc_high[i] && !phase_pwm_in[i]
      && shutdown_flag_n) [*8] |-> !gate_high[i] && !gate_low[i]) else $error("low limit");
  end
endmodule

// >>> tb/tb_top.sv
// Bench: controller end and device end joined by the link.
// Assumes the logic/ files compile first; stimulus moves at falling edges.
`timescale 1ns/1ps
module tb_top;
  logic       sys_clk = 1'b0, rst = 1'b1, latched_sel = 1'b0, clear_req = 1'b0;
  logic       over_temp_warn = 1'b0, over_temp_shut = 1'b0, supply_low = 1'b0;
  logic       power_up_clear = 1'b0, warn_seen, fault_seen, clear_busy;
  logic [2:0] pwm_req = 3'h0, bridge_enable = 3'h0, oc_high = 3'h0, oc_low = 3'h0;
  logic [2:0] oc_short = 3'h0, gate_high, gate_low;
  int         errors = 0, samples_checked = 0;
  bridge_prot_if link_if ();
  bridge_prot_ctrl u_bridge_prot_ctrl (.sys_clk, .rst, .link(link_if), .pwm_req,
    .bridge_enable, .latched_sel, .clear_req, .warn_seen, .fault_seen, .clear_busy);
  bridge_prot_device u_bridge_prot_device (.sys_clk, .rst, .link(link_if), .over_temp_warn,
    .over_temp_shut, .supply_low, .power_up_clear, .oc_high, .oc_low, .oc_short,
    .gate_high, .gate_low);
  bridge_prot_sva u_bridge_prot_sva (.sys_clk, .rst, .phase_pwm_in(link_if.phase_pwm_in),
    .bridge_clear_n(link_if.bridge_clear_n), .protect_mode_sel(link_if.protect_mode_sel),
    .temp_warning_n(link_if.temp_warning_n), .shutdown_flag_n(link_if.shutdown_flag_n),
    .over_temp_warn, .over_temp_shut, .supply_low, .power_up_clear, .oc_high, .oc_low,
    .oc_short, .gate_high, .gate_low);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  initial forever #5 sys_clk = ~sys_clk;
  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Snapshot: high gates, low gates, warning, shutdown
  function automatic logic [7:0] st();
    return {gate_high, gate_low, link_if.temp_warning_n, link_if.shutdown_flag_n};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // One cycle request; the controller pulls all three pins low, then back
  task automatic pulse_clear();
    clear_req = 1'b1;
    wait_n(1);
    clear_req = 1'b0;
    chk({4'h0, clear_busy, link_if.bridge_clear_n}, 8'h08, "clear pulse");
    wait_n(10);
  endtask
  task automatic toggle_pins(input logic [2:0] low_mask);
    bridge_enable = ~low_mask;
    wait_n(2);
    bridge_enable = 3'h7;
    wait_n(10);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_run_warn();
    pwm_req = 3'h5;
    wait_n(8);
    chk(st(), {3'h5, 3'h2, 2'h3}, "run");
    over_temp_warn = 1'b1;
    wait_n(8);
    chk(st(), {3'h5, 3'h2, 2'h1}, "warn");
    chk({6'h00, warn_seen, fault_seen}, 8'h02, "warn seen");
    over_temp_warn = 1'b0;
    $display("t_run_warn done");
  endtask
  task automatic t_thermal();
    over_temp_warn = 1'b1;
    over_temp_shut = 1'b1;
    wait_n(8);
    chk(st(), 8'h00, "hot");
    chk({6'h00, warn_seen, fault_seen}, 8'h03, "both seen");
    over_temp_shut = 1'b0;
    over_temp_warn = 1'b0;
    wait_n(10);
    chk(st(), 8'h02, "hot held");
    pulse_clear();
    chk(st(), {3'h5, 3'h2, 2'h3}, "hot cleared");
    $display("t_thermal done");
  endtask
  // Supply low and power-up clear both recover with no pin action
  task automatic t_auto_recover();
    for (int k = 0; k < 2; k++) begin
      {power_up_clear, supply_low} = 2'h1 << k;
      wait_n(8);
      chk(st(), 8'h02, "forced off");
      {power_up_clear, supply_low} = 2'h0;
      wait_n(8);
      chk(st(), {3'h5, 3'h2, 2'h3}, "recovered");
    end
    $display("t_auto_recover done");
  endtask
  task automatic t_cycle_short();
    bridge_enable = 3'h6;
    wait_n(8);
    chk({2'h0, gate_high, gate_low}, {2'h0, 3'h4, 3'h2}, "pin off");
    bridge_enable = 3'h7;
    oc_short = 3'h2;
    wait_n(8);
    chk(st(), {3'h5, 3'h0, 2'h2}, "short");
    oc_short = 3'h0;
    toggle_pins(3'h1);
    chk(st(), {3'h5, 3'h0, 2'h2}, "other pin");
    toggle_pins(3'h2);
    chk(st(), {3'h5, 3'h2, 2'h3}, "own pin");
    $display("t_cycle_short done");
  endtask
  task automatic t_latched();
    latched_sel = 1'b1;
    wait_n(4);
    oc_high = 3'h1;
    wait_n(8);
    chk(st(), 8'h02, "latched trip");
    oc_high = 3'h0;
    toggle_pins(3'h3);
    chk(st(), 8'h02, "two pins");
    pulse_clear();
    chk(st(), {3'h5, 3'h2, 2'h3}, "all pins");
    latched_sel = 1'b0;
    wait_n(4);
    $display("t_latched done");
  endtask
  task automatic t_limit();
    oc_high = 3'h4;
    wait_n(8);
    oc_high = 3'h0;
    wait_n(4);
    chk({2'h0, gate_high, gate_low}, {2'h0, 3'h1, 3'h6}, "high limit");
    // A fresh pwm rise ends the high limit before the low side trips
    pwm_req = 3'h1;
    wait_n(8);
    pwm_req = 3'h5;
    wait_n(8);
    chk(st(), {3'h5, 3'h2, 2'h3}, "limit ended");
    pwm_req = 3'h1;
    wait_n(8);
    oc_low = 3'h4;
    wait_n(8);
    oc_low = 3'h0;
    wait_n(4);
    chk({2'h0, gate_high, gate_low}, {2'h0, 3'h1, 3'h2}, "low limit");
    pwm_req = 3'h5;
    wait_n(8);
    chk(st(), {3'h5, 3'h2, 2'h3}, "next cycle");
    $display("t_limit done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    wait_n(8);
    rst = 1'b0;
    bridge_enable = 3'h7;
    wait_n(2);
    t_run_warn();
    t_thermal();
    t_auto_recover();
    t_cycle_short();
    t_latched();
    t_limit();
    close_out();
  end
  // Tests need about 230 cycles; seventeen times that means a hang
  initial begin
    #40_000;
    errors++;
    $display("BAD %0t watchdog expired", $time);
    close_out();
  end
endmodule
